// >>> src/adcsq_pkg.sv
// package of constants and types for the converter sequencer
package adcsq_pkg;
    localparam int RES_BITS_DEF     = 10;
    localparam int CYC_PER_BIT_DEF  = 4;
    localparam int INSTR_CYC_DEF    = 4;
    localparam int ACQ_CYC_DEF      = 2;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam int RESULT_HIGH_LSB  = 8;
    typedef enum logic [2:0] {
        ADCSQ_OFF,
        ADCSQ_IDLE,
        ADCSQ_DELAY,
        ADCSQ_ACQ,
        ADCSQ_CONV
    } adcsq_state_t;
endpackage

// >>> src/adcsq_approx.sv
// successive approximation register with partial-result fill
`timescale 1ns/100ps
`default_nettype none
module adcsq_approx #(
    parameter int RES_BITS = 10
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                start,
    input  wire logic                step,
    input  wire logic                compare_high,
    output logic [RES_BITS-1:0]      trial,
    output logic [RES_BITS-1:0]      partial,
    output logic                     last_bit
);
    typedef struct packed {
        logic [RES_BITS-1:0] code;
        logic [RES_BITS-1:0] mask;
    } adcsq_sar_t;

    adcsq_sar_t s_r;
    adcsq_sar_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (start) begin
            s_nxt.code = '0;
            s_nxt.mask = {1'b1, {(RES_BITS-1){1'b0}}};
        end else if (step && s_r.mask != '0) begin
            if (compare_high) begin
                s_nxt.code = s_r.code | s_r.mask;
            end
            s_nxt.mask = s_r.mask >> 1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // bits not yet decided copy the last decided bit
    always_comb begin
        logic fill;
        logic seen;
        fill = 1'b0;
        seen = 1'b0;
        partial = '0;
        for (int i = RES_BITS - 1; i >= 0; i--) begin
            if (s_r.mask[i]) begin
                seen = 1'b1;
            end
            if (seen) begin
                partial[i] = fill;
            end else begin
                partial[i] = s_r.code[i];
                fill = s_r.code[i];
            end
        end
    end

    assign trial    = s_r.code | s_r.mask;
    assign last_bit = s_r.mask[0];
endmodule
`default_nettype wire

// >>> src/adcsq_sequencer.sv
// converter sequencer: start, finish, abort, sleep and trigger handling
`timescale 1ns/100ps
`default_nettype none
module adcsq_sequencer
    import adcsq_pkg::*;
#(
    parameter int RES_BITS    = adcsq_pkg::RES_BITS_DEF,
    parameter int CYC_PER_BIT = adcsq_pkg::CYC_PER_BIT_DEF,
    parameter int INSTR_CYC   = adcsq_pkg::INSTR_CYC_DEF,
    parameter int ACQ_CYC     = adcsq_pkg::ACQ_CYC_DEF
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire logic                converter_on_wr,
    input  wire logic                converter_on_in,
    input  wire logic                go_set,
    input  wire logic                go_clear,
    input  wire logic                done_flag_clear,
    input  wire logic                dedicated_rc_clock,
    input  wire logic                interrupt_enable,
    input  wire logic                sleep,
    input  wire logic                trigger_compare_unit,
    input  wire logic                compare_high,
    output logic                     converter_on,
    output logic                     go_done,
    output logic                     conversion_done_flag,
    output logic                     module_active,
    output logic                     sample_enable,
    output logic [RES_BITS-1:0]      dac_code,
    output logic [7:0]               result_high,
    output logic [7:0]               result_low,
    output logic                     wake_request,
    output logic                     trigger_timer_clear
);
    import adcsq_pkg::*;

    // bit period of one cycle would compare against a stale dac code;
    // every count must fit the 8-bit cycle counter
    if (RES_BITS < 2 || RES_BITS > 16 || CYC_PER_BIT < 2
        || CYC_PER_BIT > 256 || INSTR_CYC < 1 || INSTR_CYC > 255
        || ACQ_CYC < 1 || ACQ_CYC > 256) begin
        $error("adcsq_sequencer: unsupported parameter values");
    end

    localparam int CW = 8;

    typedef struct packed {
        adcsq_state_t    st;
        logic            on;
        logic            go;
        logic            flag;
        logic            active;
        logic            sample;
        logic [CW-1:0]   cnt;
        logic [15:0]     result;
        logic            wake;
        logic            tclr;
        logic [RES_BITS-1:0] dac;
    } adcsq_regs_t;

    adcsq_regs_t r_r;
    adcsq_regs_t r_nxt;

    logic                sar_start;
    logic                sar_step;
    logic [RES_BITS-1:0] sar_trial;
    logic [RES_BITS-1:0] sar_partial;
    logic                sar_last;

    function automatic logic [15:0] place(input logic [RES_BITS-1:0] v);
        place = 16'(v);
    endfunction

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        logic go_req;
        logic stop;
        go_req    = 1'b0;
        stop      = 1'b0;
        r_nxt     = r_r;
        sar_start = 1'b0;
        sar_step  = 1'b0;
        r_nxt.wake = 1'b0;
        r_nxt.tclr = 1'b0;
        if (converter_on_wr) begin
            r_nxt.on = converter_on_in;
        end
        if (done_flag_clear) begin
            r_nxt.flag = 1'b0;
        end
        if (trigger_compare_unit) begin
            r_nxt.tclr = 1'b1;
        end
        // a set uses the enable already held, never the one written now
        go_req = (go_set || trigger_compare_unit) && r_r.on;
        if (go_req) begin
            r_nxt.go = 1'b1;
        end else if (go_clear) begin
            r_nxt.go = 1'b0;
        end
        stop = go_clear && !go_req;
        case (r_r.st)
            ADCSQ_OFF: begin
                r_nxt.active = 1'b0;
                if (r_r.on && !sleep) begin
                    r_nxt.st     = ADCSQ_IDLE;
                    r_nxt.active = 1'b1;
                end
            end
            ADCSQ_IDLE: begin
                // a go taken while the module powered up starts here
                if (go_req || (r_r.go && !go_clear)) begin
                    r_nxt.cnt = dedicated_rc_clock ? CW'(INSTR_CYC)
                                                   : CW'(0);
                    r_nxt.st  = ADCSQ_DELAY;
                end
            end
            ADCSQ_DELAY: begin
                if (r_r.cnt != '0) begin
                    r_nxt.cnt = r_r.cnt - CW'(1);
                end else begin
                    r_nxt.st     = ADCSQ_ACQ;
                    r_nxt.sample = 1'b1;
                    r_nxt.cnt    = CW'(ACQ_CYC - 1);
                end
                if (stop) begin
                    r_nxt.st     = ADCSQ_IDLE;
                    r_nxt.sample = 1'b0;
                end
            end
            ADCSQ_ACQ: begin
                if (r_r.cnt != '0) begin
                    r_nxt.cnt = r_r.cnt - CW'(1);
                end else begin
                    r_nxt.sample = 1'b0;
                    r_nxt.st     = ADCSQ_CONV;
                    r_nxt.cnt    = CW'(CYC_PER_BIT - 1);
                    sar_start    = 1'b1;
                end
                if (stop) begin
                    r_nxt.st     = ADCSQ_IDLE;
                    r_nxt.sample = 1'b0;
                end
            end
            ADCSQ_CONV: begin
                r_nxt.dac = sar_trial;
                if (stop) begin
                    r_nxt.result = place(sar_partial);
                    r_nxt.st     = ADCSQ_IDLE;
                end else if (r_r.cnt != '0) begin
                    r_nxt.cnt = r_r.cnt - CW'(1);
                end else begin
                    sar_step  = 1'b1;
                    r_nxt.cnt = CW'(CYC_PER_BIT - 1);
                    if (sar_last) begin
                        r_nxt.result = place(sar_trial & ({RES_BITS{1'b1}}
                            ^ (compare_high ? '0 : RES_BITS'(1))));
                        r_nxt.go   = 1'b0;
                        r_nxt.flag = 1'b1;
                        r_nxt.st   = ADCSQ_IDLE;
                        if (sleep) begin
                            if (interrupt_enable) begin
                                r_nxt.wake = 1'b1;
                            end else begin
                                r_nxt.st = ADCSQ_OFF;
                                r_nxt.active = 1'b0;
                            end
                        end
                    end
                end
            end
            default: r_nxt.st = ADCSQ_OFF;
        endcase
        // sleep without the RC clock kills any conversion
        if (sleep && !dedicated_rc_clock && r_r.st != ADCSQ_OFF) begin
            r_nxt.st     = ADCSQ_OFF;
            r_nxt.active = 1'b0;
            r_nxt.sample = 1'b0;
            r_nxt.go     = 1'b0;
        end
        if (!r_nxt.on) begin
            r_nxt.st     = ADCSQ_OFF;
            r_nxt.active = 1'b0;
            r_nxt.sample = 1'b0;
            r_nxt.go     = 1'b0;
        end
    end

    // -------------------------------------------------------------
    // state register
    // -------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r_r        <= '0;
            r_r.st     <= ADCSQ_OFF;
            r_r.result <= RESULT_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    adcsq_approx #(
        .RES_BITS (RES_BITS)
    ) u_approx (
        .clock        (clock),
        .rst          (rst),
        .start        (sar_start),
        .step         (sar_step),
        .compare_high (compare_high),
        .trial        (sar_trial),
        .partial      (sar_partial),
        .last_bit     (sar_last)
    );

    assign converter_on         = r_r.on;
    assign go_done              = r_r.go;
    assign conversion_done_flag = r_r.flag;
    assign module_active        = r_r.active;
    assign sample_enable        = r_r.sample;
    assign dac_code             = r_r.dac;
    assign result_high          = r_r.result[RESULT_HIGH_LSB +: 8];
    assign result_low           = r_r.result[7:0];
    assign wake_request         = r_r.wake;
    assign trigger_timer_clear  = r_r.tclr;
endmodule
`default_nettype wire

// >>> tb/adcsq_assertions.sv
// port assertions for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module adcsq_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       converter_on_wr,
    input wire logic       go_set,
    input wire logic       go_clear,
    input wire logic       done_flag_clear,
    input wire logic       dedicated_rc_clock,
    input wire logic       sleep,
    input wire logic       trigger_compare_unit,
    input wire logic       converter_on,
    input wire logic       go_done,
    input wire logic       conversion_done_flag,
    input wire logic       module_active,
    input wire logic       wake_request,
    input wire logic       trigger_timer_clear,
    input wire logic [7:0] result_high,
    input wire logic [7:0] result_low
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_reset_clears: assert property (disable iff (1'b0)
        rst |-> !go_done && !converter_on && !module_active
        && {result_high, result_low} == 16'h0000)
        else $error("state not cleared in reset");
    a_off_no_go: assert property (
        (go_set || trigger_compare_unit) && !converter_on && !go_done
        |=> !go_done) else $error("go taken while off");
    a_go_starts: assert property (
        go_set && converter_on && module_active && !converter_on_wr
        && !go_clear && !sleep |=> go_done) else $error("go not taken");
    a_done_sticky: assert property (
        conversion_done_flag && !done_flag_clear |=> conversion_done_flag)
        else $error("done flag dropped");
    a_finish_flag: assert property (
        $rose(conversion_done_flag) |-> !go_done && $past(go_done))
        else $error("flag without finish");
    a_abort_stops: assert property (
        go_clear && go_done && !go_set && !trigger_compare_unit
        ##1 !go_set && !trigger_compare_unit |-> !go_done ##1 !go_done)
        else $error("abort ignored");
    a_sleep_kill: assert property (
        sleep && !dedicated_rc_clock && converter_on && !converter_on_wr
        |=> converter_on ##[0:2] !module_active)
        else $error("sleep did not stop module");
    a_trig_clear: assert property (
        trigger_compare_unit |=> trigger_timer_clear)
        else $error("timer clear missing");
    a_wake_pulse: assert property (
        wake_request |=> !wake_request) else $error("wake too long");
    c_abort: cover property (go_clear && go_done);
    c_finish: cover property ($rose(conversion_done_flag));
    c_wake: cover property (wake_request);
endmodule
bind adcsq_sequencer adcsq_checker u_chk (
    .clock(clock), .rst(rst), .converter_on_wr(converter_on_wr),
    .go_set(go_set), .go_clear(go_clear),
    .done_flag_clear(done_flag_clear),
    .dedicated_rc_clock(dedicated_rc_clock), .sleep(sleep),
    .trigger_compare_unit(trigger_compare_unit),
    .converter_on(converter_on), .go_done(go_done),
    .conversion_done_flag(conversion_done_flag),
    .module_active(module_active), .wake_request(wake_request),
    .trigger_timer_clear(trigger_timer_clear),
    .result_high(result_high), .result_low(result_low));
`default_nettype wire

// >>> tb/adcsq_far_model.sv
// analog source and periodic compare trigger facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module adcsq_far_model #(
    parameter int PERIOD = 48
) (
    input wire logic       clock,
    input wire logic       run,
    input wire logic [9:0] level,
    input wire logic [9:0] dac_code,
    output logic           compare_high,
    output logic           trigger
);
    int cnt = 0;
    initial trigger = 1'b0;
    assign compare_high = level >= dac_code;
    // period kept longer than one whole conversion
    always @(posedge clock) begin
        cnt <= run ? (cnt + 1) % PERIOD : 0;
        trigger <= run && cnt == PERIOD - 1;
    end
endmodule
`default_nettype wire

// >>> tb/adcsq_sequencer_bench.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`default_nettype none
module adcsq_sequencer_bench;
    localparam int INSTR = 2;
    logic clock = 0, rst = 0, rc = 0, ie = 0, slp = 0, run = 0, woke;
    logic [3:0] pls = 4'h0;
    logic [9:0] level = 10'h000, dac;
    logic cmp, trig, con, go, flag, act, smp, wake, tclr;
    logic [7:0] rh, rl;
    int bad_count = 0, checks = 0, n0, n1;
    always #12.5 clock = ~clock;
    adcsq_sequencer #(.RES_BITS(10), .CYC_PER_BIT(2), .INSTR_CYC(INSTR),
        .ACQ_CYC(1)) DUT (.clock(clock), .rst(rst),
        .converter_on_wr(pls[3]), .converter_on_in(1'b1),
        .go_set(pls[0]), .go_clear(pls[1]), .done_flag_clear(pls[2]),
        .dedicated_rc_clock(rc), .interrupt_enable(ie), .sleep(slp),
        .trigger_compare_unit(trig), .compare_high(cmp),
        .converter_on(con), .go_done(go), .conversion_done_flag(flag),
        .module_active(act), .sample_enable(smp), .dac_code(dac),
        .result_high(rh), .result_low(rl), .wake_request(wake),
        .trigger_timer_clear(tclr));
    adcsq_far_model #(.PERIOD(48)) far (.clock(clock), .run(run),
        .level(level), .dac_code(dac), .compare_high(cmp),
        .trigger(trig));
    task automatic final_report();
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // status nibble: on, active, go, flag
    function automatic logic [15:0] st();
        return {12'h000, con, act, go, flag};
    endfunction
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clock) pls <= m;
        @(posedge clock) pls <= 4'h0;
        #1;
    endtask
    task automatic to_sample(output int n);
        for (n = 0; n < 60 && smp !== 1'b1; n++) tick();
    endtask
    task automatic to_idle();
        woke = 1'b0;
        for (int i = 0; i < 80 && go !== 1'b0; i++) tick();
        repeat (2) begin
            woke |= wake;
            tick();
        end
    endtask
    initial begin
        // a real edge on rst so the asynchronous reset acts at time zero
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        tick();
        chk("reset", 16'h0000, {rh, rl} | st());
        pulse(4'h1);
        chk("off go", 16'h0000, st());
        pulse(4'h8);
        repeat (2) tick();
        chk("on", 16'h000C, st());
        @(posedge clock) level <= 10'h2B5;
        pulse(4'h1);
        to_sample(n0);
        to_idle();
        chk("done", 16'h000D, st());
        chk("result", 16'h02B5, {rh, rl});
        repeat (5) tick();
        chk("sticky", 16'h000D, st());
        pulse(4'h4);
        @(posedge clock) rc <= 1'b1;
        pulse(4'h1);
        to_sample(n1);
        to_idle();
        chk("rc delay", 16'(INSTR), 16'(n1 - n0));
        @(posedge clock) level <= 10'h3FF;
        rc <= 1'b0;
        pulse(4'h4);
        pulse(4'h1);
        to_sample(n0);
        for (int i = 0; i < 20 && smp !== 1'b0; i++) tick();
        repeat (3) tick();
        pulse(4'h2);
        tick();
        chk("abort", 16'h000C, st());
        chk("partial", 16'h03FF, {rh, rl});
        @(posedge clock) {rc, ie} <= 2'b11;
        pulse(4'h1);
        @(posedge clock) slp <= 1'b1;
        to_idle();
        chk("wake", 16'h0003, {14'h0000, woke, flag});
        @(posedge clock) ie <= 1'b0;
        pulse(4'h4);
        @(posedge clock) slp <= 1'b0;
        tick();
        pulse(4'h1);
        @(posedge clock) slp <= 1'b1;
        to_idle();
        chk("sleep off", 16'h0009, st());
        @(posedge clock) {slp, rc} <= 2'b00;
        pulse(4'h4);
        repeat (2) tick();
        pulse(4'h1);
        to_sample(n0);
        @(posedge clock) slp <= 1'b1;
        repeat (3) tick();
        chk("sleep kill", 16'h0008, st());
        @(posedge clock) slp <= 1'b0;
        run <= 1'b1;
        repeat (2) tick();
        for (int i = 0; i < 60 && trig !== 1'b1; i++) tick();
        tick();
        chk("trigger", 16'h0003, {14'h0000, tclr, go});
        @(posedge clock) run <= 1'b0;
        to_sample(n0);
        @(posedge clock) rst <= 1'b1;
        tick();
        chk("mid reset", 16'h0000, {rh, rl} | st());
        final_report();
    end
    initial begin
        repeat (4000) @(posedge clock);
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
